// ==== hw/iopj_axis.sv ====
`default_nettype none
`include "iopj_map.svh"
module iopj_axis
  import iopj_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire logic en_i,
  input wire iopj_pkg::iopj_mv_t mv_i,
  input wire iopj_pkg::iopj_spd_t max_spd_i,
  input wire iopj_pkg::iopj_spd_t delta_i,
  input wire iopj_pkg::iopj_mv_t tol_i,
  input wire iopj_pkg::iopj_pos_t lim_no_i,
  input wire iopj_pkg::iopj_pos_t lim_ni_i,
  input wire iopj_pkg::iopj_pos_t lim_pi_i,
  input wire iopj_pkg::iopj_pos_t lim_po_i,
  input wire iopj_pkg::iopj_pos_t pos_i,
  input wire logic dir_inv_i,
  output iopj_pkg::iopj_spd_t speed_o,
  output logic dir_o
);
  logic signed [17:0] vel_r, vel_nxt, tgt, diff;
  logic signed [13:0] dev;
  logic [12:0] mag;
  logic [28:0] prod;
  logic [15:0] tgt_mag;
  logic in_zone, stop_pos, stop_neg;
  iopj_spd_t speed_nxt;

  always_comb begin
    dev = $signed({1'b0, mv_i}) - $signed(`IOPJ_MV_MID);
    mag = dev[13] ? 13'(-dev) : dev[12:0];
    in_zone = mag <= tol_i;
    prod = 29'(max_spd_i) * 29'(mag);
    tgt_mag = 16'(prod / 29'(`IOPJ_MV_MID));
    if ((!dev[13] && pos_i > lim_pi_i) || (dev[13] && pos_i < lim_ni_i))
      tgt_mag = tgt_mag >> `IOPJ_INNER_SHIFT;
    stop_pos = pos_i >= lim_po_i;
    stop_neg = pos_i <= lim_no_i;
    tgt = dev[13] ? -$signed({2'b00, tgt_mag}) : $signed({2'b00, tgt_mag});
    if (!en_i || in_zone || (!dev[13] && stop_pos) || (dev[13] && stop_neg))
      tgt = '0;
    diff = tgt - vel_r;
    vel_nxt = vel_r;
    if (tick_i) begin
      if (diff > $signed({2'b00, delta_i}))
        vel_nxt = vel_r + $signed({2'b00, delta_i});
      else if (diff < -$signed({2'b00, delta_i}))
        vel_nxt = vel_r - $signed({2'b00, delta_i});
      else
        vel_nxt = tgt;
    end
    if (!en_i || (vel_nxt > 0 && stop_pos) || (vel_nxt < 0 && stop_neg))
      vel_nxt = '0;
    speed_nxt = vel_nxt[17] ? 16'(-vel_nxt) : vel_nxt[15:0];
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      vel_r <= '0;
      speed_o <= '0;
      dir_o <= 1'b0;
    end else begin
      vel_r <= vel_nxt;
      speed_o <= speed_nxt;
      dir_o <= vel_nxt[17] ^ dir_inv_i;
    end
  end

  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);

  a_outer_pos: assert property (stop_pos |=> vel_r <= 0)
    else $error("positive outer limit not enforced");
  a_ramp_step: assert property (
    !(!en_i || stop_pos || stop_neg) && tick_i
    |=> (vel_r - $past(vel_r) <= $signed({2'b00, $past(delta_i)})) &&
        ($past(vel_r) - vel_r <= $signed({2'b00, $past(delta_i)})))
    else $error("speed change exceeds delta");
  a_dead_zone: assert property (
    in_zone && vel_r == 0 |=> vel_r == 0)
    else $error("motion inside dead zone");
  c_outer_hit: cover property (vel_r > 0 ##1 vel_r == 0 && stop_pos);
endmodule : iopj_axis
`default_nettype wire

// ==== hw/iopj_dio.sv ====
`default_nettype none
module iopj_dio (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [7:0] din_raw_i,
  input wire logic din_inv_i,
  input wire logic [7:0] dout_val_i,
  input wire logic dout_inv_i,
  output logic [7:0] status_o,
  output logic [7:0] drive_o
);
  logic [7:0] status_nxt;
  logic [7:0] drive_nxt;

  always_comb begin
    status_nxt = din_raw_i ^ {8{din_inv_i}};
    drive_nxt = dout_val_i ^ {8{dout_inv_i}};
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      status_o <= 8'h00;
      drive_o <= 8'h00;
    end else begin
      status_o <= status_nxt;
      drive_o <= drive_nxt;
    end
  end
endmodule : iopj_dio
`default_nettype wire

// ==== hw/iopj_map.svh ====
`ifndef IOPJ_MAP_SVH
`define IOPJ_MAP_SVH
// ----------------------------------------
// polarity word layout
// ----------------------------------------
`define IOPJ_POL_PULSE 0
`define IOPJ_POL_DIR 1
`define IOPJ_POL_ENC_LO 8
`define IOPJ_POL_DIN 10
`define IOPJ_POL_DOUT 11
`define IOPJ_POL_LINE0 13
`define IOPJ_POL_MASK 14'h3FE3
`define IOPJ_POL_RST 14'h0000
// ----------------------------------------
// ranges and reset values
// ----------------------------------------
`define IOPJ_BYTE_MAX 32'h000000FF
`define IOPJ_EN_MAX 32'h00000003
`define IOPJ_MV_FULL 13'h1388
`define IOPJ_MV_MID 14'h09C4
`define IOPJ_ADC_FULL 23'h0003FF
`define IOPJ_SPD_RST 16'h03E8
`define IOPJ_DEL_RST 16'h000A
`define IOPJ_TOL_RST 13'h0064
`define IOPJ_LIM_POS 32'h7FFFFFFF
`define IOPJ_LIM_NEG 32'h80000000
`define IOPJ_INNER_SHIFT 1
// ----------------------------------------
// timing
// ----------------------------------------
`define IOPJ_CLK_NS 10
`define IOPJ_TICK_NS 1000000
`define IOPJ_TICK_CYC (`IOPJ_TICK_NS / `IOPJ_CLK_NS)
`endif

// ==== hw/iopj_pkg.sv ====
`default_nettype none
package iopj_pkg;
  `include "iopj_map.svh"

  typedef enum logic [3:0] {
    SEL_DIN, SEL_DIN_BIT, SEL_DOUT, SEL_DOUT_BIT, SEL_BOOT, SEL_STORE,
    SEL_AIN, SEL_STICK_EN, SEL_MAXSPD, SEL_DELTA, SEL_TOL, SEL_LIMIT,
    SEL_POL
  } iopj_sel_e;

  typedef logic signed [31:0] iopj_pos_t;
  typedef logic [15:0] iopj_spd_t;
  typedef logic [12:0] iopj_mv_t;

  // converter code to millivolts
  function automatic iopj_mv_t iopj_mv_of(input logic [9:0] code);
    logic [22:0] p;
    p = 23'(code) * 23'(`IOPJ_MV_FULL);
    return 13'(p / `IOPJ_ADC_FULL);
  endfunction : iopj_mv_of

  // decoding multiplier from polarity bits 9:8
  function automatic logic [2:0] iopj_enc_mult(input logic [1:0] code);
    case (code)
      2'h1: return 3'h2;
      2'h2: return 3'h4;
      default: return 3'h1;
    endcase
  endfunction : iopj_enc_mult
endpackage : iopj_pkg
`default_nettype wire

// ==== hw/iopj_top.sv ====
`default_nettype none
`include "iopj_map.svh"
module iopj_top
  import iopj_pkg::*;
#(
  parameter int TICK_CYCLES = `IOPJ_TICK_CYC
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic cmd_valid_i,
  input wire logic cmd_write_i,
  input wire iopj_pkg::iopj_sel_e cmd_sel_i,
  input wire logic [3:0] cmd_idx_i,
  input wire logic [31:0] cmd_data_i,
  input wire logic [7:0] din_raw_i,
  input wire logic [7:0] boot_nv_i,
  input wire logic [9:0] adc_x_i,
  input wire logic [9:0] adc_y_i,
  input wire iopj_pkg::iopj_pos_t pos_x_i,
  input wire iopj_pkg::iopj_pos_t pos_y_i,
  output logic rsp_valid_o,
  output logic rsp_err_o,
  output logic [31:0] rsp_data_o,
  output logic [7:0] dout_o,
  output logic boot_store_o,
  output logic [7:0] boot_data_o,
  output iopj_pkg::iopj_spd_t x_speed_o,
  output logic x_dir_o,
  output iopj_pkg::iopj_spd_t y_speed_o,
  output logic y_dir_o,
  output logic [1:0] verify_off_o,
  output logic [13:0] pol_x_o,
  output logic [13:0] pol_y_o,
  output logic [2:0] enc_mult_x_o,
  output logic [2:0] enc_mult_y_o,
  output logic [1:0] err_line0_o
);
  import iopj_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [7:0] dout_r, dout_nxt, boot_r, boot_nxt;
  logic boot_load_r, boot_load_nxt, store_nxt;
  logic [13:0] pol_r [2], pol_nxt [2];
  logic [2:0] enc_r [2], enc_nxt [2];
  logic [1:0] en_r, en_nxt;
  iopj_spd_t spd_r [2], spd_nxt [2], del_r [2], del_nxt [2];
  iopj_mv_t tol_r [2], tol_nxt [2], mv_r [2], mv_nxt [2];
  iopj_pos_t lim_r [8], lim_nxt [8];
  logic rsp_valid_nxt, rsp_err_nxt;
  logic [31:0] rsp_data_nxt;
  logic [31:0] tick_cnt_r, tick_cnt_nxt;
  logic tick;
  logic [7:0] din_stat;
  logic [2:0] bit_i;
  logic ax, idx8_ok, idx2_ok, wr;

  function automatic logic in_range(input logic [3:0] idx,
                                    input logic [3:0] top);
    return idx >= 4'h1 && idx <= top;
  endfunction : in_range

  // ----------------------------------------
  // digital io
  // ----------------------------------------
  iopj_dio u_dio (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .din_raw_i(din_raw_i),
    .din_inv_i(pol_r[0][`IOPJ_POL_DIN]),
    .dout_val_i(dout_r),
    .dout_inv_i(pol_r[0][`IOPJ_POL_DOUT]),
    .status_o(din_stat),
    .drive_o(dout_o)
  );

  // ----------------------------------------
  // stick axes
  // ----------------------------------------
  iopj_axis u_ax_x (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .tick_i(tick),
    .en_i(en_r[0]),
    .mv_i(mv_r[0]),
    .max_spd_i(spd_r[0]),
    .delta_i(del_r[0]),
    .tol_i(tol_r[0]),
    .lim_no_i(lim_r[0]),
    .lim_ni_i(lim_r[1]),
    .lim_pi_i(lim_r[2]),
    .lim_po_i(lim_r[3]),
    .pos_i(pos_x_i),
    .dir_inv_i(pol_r[0][`IOPJ_POL_DIR]),
    .speed_o(x_speed_o),
    .dir_o(x_dir_o)
  );

  iopj_axis u_ax_y (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .tick_i(tick),
    .en_i(en_r[1]),
    .mv_i(mv_r[1]),
    .max_spd_i(spd_r[1]),
    .delta_i(del_r[1]),
    .tol_i(tol_r[1]),
    .lim_no_i(lim_r[4]),
    .lim_ni_i(lim_r[5]),
    .lim_pi_i(lim_r[6]),
    .lim_po_i(lim_r[7]),
    .pos_i(pos_y_i),
    .dir_inv_i(pol_r[1][`IOPJ_POL_DIR]),
    .speed_o(y_speed_o),
    .dir_o(y_dir_o)
  );

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  always_comb begin
    tick = tick_cnt_r == 32'(TICK_CYCLES - 1);
    tick_cnt_nxt = tick ? 32'h0 : tick_cnt_r + 32'h1;
    mv_nxt[0] = iopj_mv_of(adc_x_i);
    mv_nxt[1] = iopj_mv_of(adc_y_i);
    bit_i = 3'(cmd_idx_i - 4'h1);
    ax = ~cmd_idx_i[0];
    idx8_ok = in_range(cmd_idx_i, 4'h8);
    idx2_ok = in_range(cmd_idx_i, 4'h2);
    wr = cmd_valid_i && cmd_write_i && !boot_load_r;
    dout_nxt = dout_r;
    boot_nxt = boot_r;
    boot_load_nxt = 1'b0;
    store_nxt = 1'b0;
    pol_nxt = pol_r;
    en_nxt = en_r;
    spd_nxt = spd_r;
    del_nxt = del_r;
    tol_nxt = tol_r;
    lim_nxt = lim_r;
    rsp_valid_nxt = cmd_valid_i && !boot_load_r;
    rsp_err_nxt = 1'b0;
    rsp_data_nxt = 32'h0;
    if (boot_load_r) begin
      dout_nxt = boot_nv_i;
      boot_nxt = boot_nv_i;
    end
    if (cmd_valid_i && !boot_load_r) begin
      case (cmd_sel_i)
        SEL_DIN: begin
          rsp_data_nxt = {24'h0, din_stat};
          rsp_err_nxt = cmd_write_i;
        end
        SEL_DIN_BIT: begin
          rsp_data_nxt = {31'h0, din_stat[bit_i]};
          rsp_err_nxt = cmd_write_i || !idx8_ok;
        end
        SEL_DOUT: begin
          rsp_data_nxt = {24'h0, dout_r};
          rsp_err_nxt = wr && cmd_data_i > `IOPJ_BYTE_MAX;
          if (wr && !rsp_err_nxt)
            dout_nxt = cmd_data_i[7:0];
        end
        SEL_DOUT_BIT: begin
          rsp_data_nxt = {31'h0, dout_r[bit_i]};
          rsp_err_nxt = !idx8_ok;
          if (wr && idx8_ok)
            dout_nxt[bit_i] = cmd_data_i[0];
        end
        SEL_BOOT: begin
          rsp_data_nxt = {24'h0, boot_r};
          rsp_err_nxt = wr && cmd_data_i > `IOPJ_BYTE_MAX;
          if (wr && !rsp_err_nxt)
            boot_nxt = cmd_data_i[7:0];
        end
        SEL_STORE: store_nxt = wr;
        SEL_AIN: begin
          rsp_data_nxt = {19'h0, mv_r[bit_i[0]]};
          rsp_err_nxt = cmd_write_i || !idx2_ok;
        end
        SEL_STICK_EN: begin
          rsp_data_nxt = {30'h0, en_r};
          rsp_err_nxt = wr && cmd_data_i > `IOPJ_EN_MAX;
          if (wr && !rsp_err_nxt)
            en_nxt = cmd_data_i[1:0];
        end
        SEL_MAXSPD: begin
          rsp_data_nxt = {16'h0, spd_r[ax]};
          rsp_err_nxt = !idx2_ok || (wr && cmd_data_i[31:16] != 16'h0);
          if (wr && !rsp_err_nxt)
            spd_nxt[ax] = cmd_data_i[15:0];
        end
        SEL_DELTA: begin
          rsp_data_nxt = {16'h0, del_r[ax]};
          rsp_err_nxt = !idx2_ok || (wr && cmd_data_i[31:16] != 16'h0);
          if (wr && !rsp_err_nxt)
            del_nxt[ax] = cmd_data_i[15:0];
        end
        SEL_TOL: begin
          rsp_data_nxt = {19'h0, tol_r[ax]};
          rsp_err_nxt = !idx2_ok ||
            (wr && cmd_data_i > 32'(`IOPJ_MV_FULL));
          if (wr && !rsp_err_nxt)
            tol_nxt[ax] = cmd_data_i[12:0];
        end
        SEL_LIMIT: begin
          rsp_data_nxt = lim_r[bit_i];
          rsp_err_nxt = !idx8_ok;
          if (wr && idx8_ok)
            lim_nxt[bit_i] = cmd_data_i;
        end
        SEL_POL: begin
          rsp_data_nxt = {18'h0, pol_r[ax]};
          rsp_err_nxt = !idx2_ok;
          if (wr && idx2_ok)
            pol_nxt[ax] = cmd_data_i[13:0] & `IOPJ_POL_MASK;
        end
        default: rsp_err_nxt = 1'b1;
      endcase
    end
    for (int i = 0; i < 2; i++)
      enc_nxt[i] = iopj_enc_mult(pol_nxt[i][9:8]);
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      dout_r <= 8'h00;
      boot_r <= 8'h00;
      boot_load_r <= 1'b1;
      boot_store_o <= 1'b0;
      en_r <= 2'h0;
      rsp_valid_o <= 1'b0;
      rsp_err_o <= 1'b0;
      rsp_data_o <= 32'h0;
      tick_cnt_r <= 32'h0;
      for (int i = 0; i < 2; i++) begin
        pol_r[i] <= `IOPJ_POL_RST;
        enc_r[i] <= 3'h1;
        spd_r[i] <= `IOPJ_SPD_RST;
        del_r[i] <= `IOPJ_DEL_RST;
        tol_r[i] <= `IOPJ_TOL_RST;
        mv_r[i] <= 13'h0000;
      end
      for (int i = 0; i < 8; i++)
        lim_r[i] <= i[1] ? `IOPJ_LIM_POS : `IOPJ_LIM_NEG;
    end else begin
      dout_r <= dout_nxt;
      boot_r <= boot_nxt;
      boot_load_r <= boot_load_nxt;
      boot_store_o <= store_nxt;
      en_r <= en_nxt;
      rsp_valid_o <= rsp_valid_nxt;
      rsp_err_o <= rsp_err_nxt;
      rsp_data_o <= rsp_data_nxt;
      tick_cnt_r <= tick_cnt_nxt;
      pol_r <= pol_nxt;
      enc_r <= enc_nxt;
      spd_r <= spd_nxt;
      del_r <= del_nxt;
      tol_r <= tol_nxt;
      mv_r <= mv_nxt;
      lim_r <= lim_nxt;
    end
  end

  // ----------------------------------------
  // configuration outputs
  // ----------------------------------------
  assign boot_data_o = boot_r;
  assign verify_off_o = en_r;
  assign pol_x_o = pol_r[0];
  assign pol_y_o = pol_r[1];
  assign enc_mult_x_o = enc_r[0];
  assign enc_mult_y_o = enc_r[1];
  assign err_line0_o = {pol_r[1][`IOPJ_POL_LINE0],
                        pol_r[0][`IOPJ_POL_LINE0]};

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);

  a_din_word: assert property (
    cmd_valid_i && !boot_load_r && cmd_sel_i == SEL_DIN |=>
    rsp_valid_o && rsp_data_o[7:0] == $past(din_stat))
    else $error("input word mismatch");
  a_din_bit: assert property (
    cmd_valid_i && !boot_load_r && cmd_sel_i == SEL_DIN_BIT &&
    cmd_idx_i == 4'h1 |=> rsp_data_o[0] == $past(din_stat[0]))
    else $error("input bit one not bit zero");
  a_din_level: assert property (
    ##1 din_stat == ($past(din_raw_i) ^
    {8{$past(pol_r[0][`IOPJ_POL_DIN])}}))
    else $error("input status level wrong");
  a_dout_full: assert property (
    wr && cmd_sel_i == SEL_DOUT |=>
    ($past(cmd_data_i) > `IOPJ_BYTE_MAX) ? (rsp_err_o && $stable(dout_r))
    : (dout_r == $past(cmd_data_i[7:0])))
    else $error("output word write wrong");
  a_dout_bit: assert property (
    wr && cmd_sel_i == SEL_DOUT_BIT &&
    cmd_idx_i == 4'h8 |=> dout_r[7] == $past(cmd_data_i[0]) &&
    dout_r[6:0] == $past(dout_r[6:0]))
    else $error("output bit eight wrong");
  a_dout_drive: assert property (
    ##1 dout_o == ($past(dout_r) ^
    {8{$past(pol_r[0][`IOPJ_POL_DOUT])}}))
    else $error("output drive level wrong");
  a_dout_hold: assert property (
    !boot_load_r && !(cmd_valid_i && cmd_write_i) |=> $stable(dout_r))
    else $error("output changed without write");
  a_boot_load: assert property (
    boot_load_r && !rst_i |=> dout_r == $past(boot_nv_i) && !boot_load_r)
    else $error("boot value not loaded");
  a_ain_range: assert property (
    mv_r[0] <= `IOPJ_MV_FULL && mv_r[1] <= `IOPJ_MV_FULL)
    else $error("analog reading out of range");
  a_stick_off: assert property (
    !en_r[0] ##1 !en_r[0] |-> x_speed_o == 16'h0)
    else $error("x moves while disabled");
  a_pol_unused: assert property (
    pol_r[0][4:2] == 3'h0 && pol_r[1][4:2] == 3'h0)
    else $error("unused polarity bits set");
  a_enc_mult: assert property (
    enc_r[0] == (pol_r[0][9:8] == 2'h1 ? 3'h2 :
    pol_r[0][9:8] == 2'h2 ? 3'h4 : 3'h1))
    else $error("encoder multiplier wrong");
  c_dout_write: cover property (wr && cmd_sel_i == SEL_DOUT);
  c_store: cover property (boot_store_o);
  c_stick_run: cover property (en_r[0] && x_speed_o != 16'h0);
endmodule : iopj_top
`default_nettype wire

// ==== test/iopj_far_model.sv ====
`default_nettype none
module iopj_far_model
  import iopj_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [7:0] sw_i,
  input wire logic [9:0] knob_x_i,
  input wire logic [9:0] knob_y_i,
  input wire iopj_pkg::iopj_pos_t at_x_i,
  input wire iopj_pkg::iopj_pos_t at_y_i,
  output logic [7:0] din_raw_o,
  output logic [9:0] adc_x_o,
  output logic [9:0] adc_y_o,
  output iopj_pkg::iopj_pos_t pos_x_o,
  output iopj_pkg::iopj_pos_t pos_y_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // switches, converters and axis encoders
  // ----------------------------------------
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      din_raw_o <= 8'h00;
      adc_x_o <= 10'h000;
      adc_y_o <= 10'h000;
      pos_x_o <= 32'h00000000;
      pos_y_o <= 32'h00000000;
    end else begin
      din_raw_o <= sw_i;
      adc_x_o <= knob_x_i;
      adc_y_o <= knob_y_i;
      pos_x_o <= at_x_i;
      pos_y_o <= at_y_i;
    end
  end
endmodule : iopj_far_model
`default_nettype wire

// ==== test/iopj_top_tb.sv ====
`default_nettype none
module iopj_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import iopj_pkg::*;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic cmd_valid_i = 1'b0;
  logic cmd_write_i = 1'b0;
  iopj_sel_e cmd_sel_i = SEL_DIN;
  logic [3:0] cmd_idx_i = 4'h1;
  logic [31:0] cmd_data_i = 32'h0;
  logic [7:0] boot_nv = 8'hA5;
  logic [7:0] sw = 8'h00;
  logic [9:0] kx = 10'h000;
  logic [9:0] ky = 10'h000;
  iopj_pos_t px = 32'h0;
  iopj_pos_t py = 32'h0;
  logic [7:0] din_raw_i;
  logic [9:0] adc_x_i;
  logic [9:0] adc_y_i;
  iopj_pos_t pos_x_i;
  iopj_pos_t pos_y_i;
  logic rsp_valid_o, rsp_err_o, boot_store_o, x_dir_o, y_dir_o;
  logic [31:0] rsp_data_o;
  logic [7:0] dout_o, boot_data_o;
  iopj_spd_t x_speed_o, y_speed_o;
  logic [1:0] verify_off_o, err_line0_o;
  logic [13:0] pol_x_o, pol_y_o;
  logic [2:0] enc_mult_x_o, enc_mult_y_o;
  logic [31:0] rd;
  logic er, st;
  int n_errors = 0;
  int total_checks = 0;

  always #5 clock_i = ~clock_i;

  iopj_top #(.TICK_CYCLES(4)) iopj_top_i (
    .clock_i(clock_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i),
    .cmd_write_i(cmd_write_i), .cmd_sel_i(cmd_sel_i),
    .cmd_idx_i(cmd_idx_i), .cmd_data_i(cmd_data_i),
    .din_raw_i(din_raw_i), .boot_nv_i(boot_nv), .adc_x_i(adc_x_i),
    .adc_y_i(adc_y_i), .pos_x_i(pos_x_i), .pos_y_i(pos_y_i),
    .rsp_valid_o(rsp_valid_o), .rsp_err_o(rsp_err_o),
    .rsp_data_o(rsp_data_o), .dout_o(dout_o),
    .boot_store_o(boot_store_o), .boot_data_o(boot_data_o),
    .x_speed_o(x_speed_o), .x_dir_o(x_dir_o), .y_speed_o(y_speed_o),
    .y_dir_o(y_dir_o), .verify_off_o(verify_off_o), .pol_x_o(pol_x_o),
    .pol_y_o(pol_y_o), .enc_mult_x_o(enc_mult_x_o),
    .enc_mult_y_o(enc_mult_y_o), .err_line0_o(err_line0_o)
  );

  iopj_far_model iopj_far_model_i (
    .clock_i(clock_i), .rst_i(rst_i), .sw_i(sw), .knob_x_i(kx),
    .knob_y_i(ky), .at_x_i(px), .at_y_i(py), .din_raw_o(din_raw_i),
    .adc_x_o(adc_x_i), .adc_y_o(adc_y_i), .pos_x_o(pos_x_i),
    .pos_y_o(pos_y_i)
  );

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : wait_cyc

  task automatic cmd(input logic wr, input iopj_sel_e sel,
                     input logic [3:0] idx, input logic [31:0] d);
    @(posedge clock_i);
    cmd_valid_i <= 1'b1;
    cmd_write_i <= wr;
    cmd_sel_i <= sel;
    cmd_idx_i <= idx;
    cmd_data_i <= d;
    @(posedge clock_i);
    cmd_valid_i <= 1'b0;
    #1;
    chk(rsp_valid_o, 1'b1);
    rd = rsp_data_o;
    er = rsp_err_o;
    st = boot_store_o;
  endtask : cmd

  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_boot;
    wait_cyc(3);
    chk(dout_o, 8'hA5);
    chk(boot_data_o, 8'hA5);
    chk(pol_x_o, 14'h0000);
    chk(enc_mult_x_o, 3'h1);
  endtask : t_boot

  task automatic t_din;
    sw <= 8'h5A;
    wait_cyc(4);
    cmd(1'b0, SEL_DIN, 4'h1, 32'h0);
    chk(rd, 32'h5A);
    for (int i = 1; i <= 8; i++) begin
      cmd(1'b0, SEL_DIN_BIT, 4'(i), 32'h0);
      chk(rd, (32'h5A >> (i - 1)) & 32'h1);
    end
    cmd(1'b0, SEL_DIN_BIT, 4'h9, 32'h0);
    chk(er, 1'b1);
    cmd(1'b1, SEL_DIN, 4'h1, 32'hFF);
    chk(er, 1'b1);
    cmd(1'b1, SEL_POL, 4'h1, 32'h400);
    wait_cyc(4);
    cmd(1'b0, SEL_DIN, 4'h1, 32'h0);
    chk(rd, 32'hA5);
    cmd(1'b1, SEL_POL, 4'h1, 32'h0);
  endtask : t_din

  task automatic t_dout;
    cmd(1'b1, SEL_DOUT, 4'h1, 32'h3C);
    wait_cyc(1);
    chk(dout_o, 8'h3C);
    cmd(1'b1, SEL_DOUT, 4'h1, 32'h100);
    chk(er, 1'b1);
    wait_cyc(3);
    chk(dout_o, 8'h3C);
    cmd(1'b1, SEL_DOUT, 4'h1, 32'h0);
    for (int i = 1; i <= 8; i++) begin
      cmd(1'b1, SEL_DOUT_BIT, 4'(i), 32'h1);
      wait_cyc(1);
      chk(dout_o, (32'h1 << i) - 32'h1);
    end
    cmd(1'b1, SEL_DOUT_BIT, 4'h3, 32'h0);
    cmd(1'b0, SEL_DOUT_BIT, 4'h3, 32'h0);
    chk(rd, 32'h0);
    cmd(1'b1, SEL_DOUT_BIT, 4'h0, 32'h1);
    chk(er, 1'b1);
    cmd(1'b1, SEL_POL, 4'h1, 32'h800);
    wait_cyc(2);
    chk(dout_o, 8'h04);
    cmd(1'b0, SEL_DOUT, 4'h1, 32'h0);
    chk(rd, 32'hFB);
    cmd(1'b1, SEL_POL, 4'h1, 32'h0);
  endtask : t_dout

  task automatic t_store;
    cmd(1'b1, SEL_BOOT, 4'h1, 32'h77);
    chk(st, 1'b0);
    cmd(1'b0, SEL_BOOT, 4'h1, 32'h0);
    chk(rd, 32'h77);
    chk(boot_data_o, 8'h77);
    chk(dout_o, 8'hFB);
    cmd(1'b1, SEL_BOOT, 4'h1, 32'h12C);
    chk(er, 1'b1);
    cmd(1'b1, SEL_STORE, 4'h1, 32'h0);
    chk(st, 1'b1);
    wait_cyc(1);
    chk(boot_store_o, 1'b0);
  endtask : t_store

  task automatic t_analog;
    kx <= 10'h3FF;
    ky <= 10'h200;
    wait_cyc(4);
    cmd(1'b0, SEL_AIN, 4'h1, 32'h0);
    chk(rd, 32'h1388);
    cmd(1'b0, SEL_AIN, 4'h2, 32'h0);
    chk(rd, 32'h9C6);
    cmd(1'b0, SEL_AIN, 4'h3, 32'h0);
    chk(er, 1'b1);
  endtask : t_analog

  task automatic t_pol;
    cmd(1'b1, SEL_POL, 4'h2, 32'h3FFF);
    cmd(1'b0, SEL_POL, 4'h2, 32'h0);
    chk(rd, 32'h3FE3);
    chk(pol_y_o, 14'h3FE3);
    chk(enc_mult_y_o, 3'h1);
    chk(err_line0_o, 2'b10);
    for (int c = 0; c < 4; c++) begin
      cmd(1'b1, SEL_POL, 4'h1, 32'(c) << 8);
      wait_cyc(1);
      chk(enc_mult_x_o, c == 1 ? 3'h2 : c == 2 ? 3'h4 : 3'h1);
    end
    cmd(1'b1, SEL_POL, 4'h1, 32'h2000);
    wait_cyc(1);
    chk(err_line0_o, 2'b11);
    cmd(1'b1, SEL_POL, 4'h1, 32'h0);
    cmd(1'b1, SEL_POL, 4'h2, 32'h0);
    wait_cyc(1);
    chk(err_line0_o, 2'b00);
    cmd(1'b1, SEL_POL, 4'h2, 32'h200);
    chk(enc_mult_y_o, 3'h4);
    cmd(1'b1, SEL_POL, 4'h2, 32'h0);
  endtask : t_pol

  task automatic t_stick;
    logic [15:0] prev;
    cmd(1'b1, SEL_DELTA, 4'h1, 32'hFFFF);
    cmd(1'b1, SEL_DELTA, 4'h2, 32'hFFFF);
    cmd(1'b1, SEL_STICK_EN, 4'h1, 32'h4);
    chk(er, 1'b1);
    cmd(1'b1, SEL_STICK_EN, 4'h1, 32'h1);
    wait_cyc(1);
    chk(verify_off_o, 2'b01);
    wait_cyc(20);
    chk(x_speed_o, 16'h03E8);
    chk(x_dir_o, 1'b0);
    chk(y_speed_o, 16'h0000);
    cmd(1'b1, SEL_POL, 4'h1, 32'h2);
    wait_cyc(2);
    chk(x_dir_o, 1'b1);
    cmd(1'b1, SEL_POL, 4'h1, 32'h0);
    kx <= 10'h226;
    wait_cyc(20);
    chk(x_speed_o, 16'h004B);
    cmd(1'b1, SEL_TOL, 4'h1, 32'hC8);
    wait_cyc(20);
    chk(x_speed_o, 16'h0000);
    cmd(1'b1, SEL_TOL, 4'h1, 32'h1389);
    chk(er, 1'b1);
    cmd(1'b1, SEL_TOL, 4'h1, 32'h64);
    cmd(1'b1, SEL_STICK_EN, 4'h1, 32'h3);
    kx <= 10'h3FF;
    ky <= 10'h000;
    wait_cyc(20);
    chk(verify_off_o, 2'b11);
    chk(y_speed_o, 16'h03E8);
    chk(y_dir_o, 1'b1);
    cmd(1'b1, SEL_LIMIT, 4'h3, 32'h64);
    cmd(1'b1, SEL_LIMIT, 4'h4, 32'hC8);
    cmd(1'b1, SEL_LIMIT, 4'h9, 32'h0);
    chk(er, 1'b1);
    px <= 32'd150;
    wait_cyc(20);
    chk(x_speed_o, 16'h01F4);
    px <= 32'd200;
    wait_cyc(3);
    chk(x_speed_o, 16'h0000);
    kx <= 10'h000;
    wait_cyc(20);
    chk(x_speed_o, 16'h03E8);
    chk(x_dir_o, 1'b1);
    px <= 32'h0;
    kx <= 10'h3FF;
    cmd(1'b1, SEL_MAXSPD, 4'h1, 32'h10000);
    chk(er, 1'b1);
    cmd(1'b1, SEL_MAXSPD, 4'h1, 32'h7D0);
    wait_cyc(20);
    chk(x_speed_o, 16'h07D0);
    cmd(1'b1, SEL_STICK_EN, 4'h1, 32'h2);
    wait_cyc(1);
    chk(x_speed_o, 16'h0000);
    chk(verify_off_o, 2'b10);
    cmd(1'b1, SEL_DELTA, 4'h1, 32'hA);
    cmd(1'b1, SEL_STICK_EN, 4'h1, 32'h1);
    prev = 16'h0000;
    for (int i = 0; i < 40; i++) begin
      wait_cyc(1);
      chk(x_speed_o - prev <= 16'h000A, 1'b1);
      prev = x_speed_o;
    end
    chk(prev > 16'h0000 && prev < 16'h07D0, 1'b1);
  endtask : t_stick

  initial begin
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    t_boot();
    t_din();
    t_dout();
    t_store();
    t_analog();
    t_pol();
    t_stick();
    test_done();
  end

  initial begin
    #200000;
    n_errors++;
    test_done();
  end
endmodule : iopj_top_tb
`default_nettype wire
